//--- hdl/hcsc_pkg.sv
package hcsc_pkg;

    // Register indices as printed; the byte address is four times the index
    localparam logic [9:0] IDX_CFG0 = 10'h140;
    localparam logic [9:0] IDX_CFG1 = 10'h141;
    localparam logic [9:0] IDX_MPS_H = 10'h142;
    localparam logic [9:0] IDX_MPS_L = 10'h143;
    localparam logic [9:0] IDX_CNT_HH = 10'h144;
    localparam logic [9:0] IDX_CNT_HL = 10'h145;
    localparam logic [9:0] IDX_CNT_LH = 10'h146;
    localparam logic [9:0] IDX_CNT_LL = 10'h147;
    localparam logic [9:0] IDX_EVT = 10'h14E;

    localparam int APB_AW = 12;
    localparam logic [11:0] ADDR_CFG0 = {IDX_CFG0, 2'b00};
    localparam logic [11:0] ADDR_CFG1 = {IDX_CFG1, 2'b00};
    localparam logic [11:0] ADDR_MPS_H = {IDX_MPS_H, 2'b00};
    localparam logic [11:0] ADDR_MPS_L = {IDX_MPS_L, 2'b00};
    localparam logic [11:0] ADDR_CNT_HH = {IDX_CNT_HH, 2'b00};
    localparam logic [11:0] ADDR_CNT_HL = {IDX_CNT_HL, 2'b00};
    localparam logic [11:0] ADDR_CNT_LH = {IDX_CNT_LH, 2'b00};
    localparam logic [11:0] ADDR_CNT_LL = {IDX_CNT_LL, 2'b00};
    localparam logic [11:0] ADDR_EVT = {IDX_EVT, 2'b00};

    // Field positions
    localparam int CFG0_GO_BIT = 0;
    localparam int CFG1_FREE_BIT = 0;
    localparam int CFG1_TID_LSB = 6;
    localparam int EVT_CMP_BIT = 0;

    // Token direction codes
    localparam logic [1:0] TID_OUT = 2'h1;
    localparam logic [1:0] TID_IN = 2'h2;

    // Reset values
    localparam logic [9:0] MPS_RST = 10'h000;
    localparam logic [31:0] CNT_RST = 32'h0000_0000;
    localparam logic [1:0] TID_RST = 2'h0;
    localparam logic [23:0] SNAP_RST = 24'h00_0000;

    localparam int MPS_W = 10;
    localparam int PKT_W = 11;

    typedef enum logic {HCSC_IDLE, HCSC_RUN} hcsc_state_e;

    // Packet report from the token engine, same clock
    typedef struct packed {
        logic done;
        logic [PKT_W-1:0] bytes;
    } hcsc_pkt_s;

    // Request to the token engine
    typedef struct packed {
        logic active;
        logic dir_out;
        logic [MPS_W-1:0] len;
        logic zero_len;
    } hcsc_req_s;

endpackage

//--- hdl/hcsc_byte_counter.sv
`timescale 1ns/100ps
module hcsc_byte_counter
    import hcsc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [3:0] byte_wr,
    input wire logic [7:0] wdata,
    input wire logic dec_en,
    input wire logic [PKT_W-1:0] dec_amt,
    output logic [31:0] count
);

    logic [31:0] count_reg;
    logic [31:0] dec_val;
    logic [31:0] count_next;

    // Saturate at zero so an oversized report cannot wrap the count
    always_comb begin
        dec_val = count_reg;
        if (dec_en) begin
            if (count_reg > {21'h0, dec_amt}) begin
                dec_val = count_reg - {21'h0, dec_amt};
            end else begin
                dec_val = 32'h0000_0000;
            end
        end
    end

    // Lane 3 is bits 31:24, lane 0 bits 7:0
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_lane
            assign count_next[8*g +: 8] = byte_wr[g] ? wdata : dec_val[8*g +: 8];
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= CNT_RST;
        end else begin
            count_reg <= count_next;
        end
    end

    assign count = count_reg;

endmodule

//--- hdl/hcsc_host_channel_size_counter.sv
// What this block does
// - Hold ten-bit max packet size, split high/low
// - Keep 32-bit unsigned total byte count
// - Count bytes: MSB lowest address, LSB highest
// - Running count reads back bytes still remaining
// - Reading top byte freezes lower three bytes
// - Zero count OUT sends one zero-length packet
// - All nine registers reset to zero
// - Go bit starts, stops, shows running state
// - Count exhausted: set complete flag, clear go
// - Unlimited flag ignores the programmed count
//
// Added by the designer: the APB slave port.
`timescale 1ns/100ps
module hcsc_host_channel_size_counter
    import hcsc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire hcsc_pkt_s pkt_report,
    output hcsc_req_s pkt_request
);

    // Bus slave state
    logic pready_reg;
    logic pready_next;
    logic pslverr_reg;
    logic pslverr_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;

    // Register state
    hcsc_state_e state_reg;
    hcsc_state_e state_next;
    logic [MPS_W-1:0] max_packet_bytes_reg;
    logic [MPS_W-1:0] max_packet_bytes_next;
    logic [1:0] tid_reg;
    logic [1:0] tid_next;
    logic unlimited_size_flag_reg;
    logic unlimited_size_flag_next;
    logic transfer_complete_flag_reg;
    logic transfer_complete_flag_next;
    logic [23:0] cap_reg;
    logic [23:0] cap_next;
    logic [23:0] snap_reg;
    logic [23:0] snap_next;
    hcsc_req_s req_reg;
    hcsc_req_s req_next;

    // Decode and counter wiring
    logic setup;
    logic access;
    logic wr_ok;
    logic rd_top;
    logic hit;
    logic [7:0] rd_byte;
    logic [7:0] wbyte;
    logic [3:0] cnt_wr;
    logic cnt_dec;
    logic complete;
    logic [31:0] transfer_byte_count;
    logic [31:0] len_wide;

    assign setup = psel & ~penable;
    assign access = psel & penable & pready_reg;
    assign wr_ok = access & pwrite & ~pslverr_reg;
    assign rd_top = access & ~pwrite & (paddr == ADDR_CNT_HH);
    assign wbyte = pwdata[7:0];

    // Read mux sampled in setup so prdata is a flop in the access cycle
    always_comb begin
        hit = 1'b1;
        rd_byte = 8'h00;
        unique case (paddr)
            ADDR_CFG0: begin
                rd_byte[CFG0_GO_BIT] = (state_reg == HCSC_RUN);
            end
            ADDR_CFG1: begin
                rd_byte[CFG1_TID_LSB +: 2] = tid_reg;
                rd_byte[CFG1_FREE_BIT] = unlimited_size_flag_reg;
            end
            ADDR_MPS_H: begin
                rd_byte = {6'h00, max_packet_bytes_reg[9:8]};
            end
            ADDR_MPS_L: begin
                rd_byte = max_packet_bytes_reg[7:0];
            end
            ADDR_CNT_HH: begin
                rd_byte = transfer_byte_count[31:24];
            end
            ADDR_CNT_HL: begin
                rd_byte = snap_reg[23:16];
            end
            ADDR_CNT_LH: begin
                rd_byte = snap_reg[15:8];
            end
            ADDR_CNT_LL: begin
                rd_byte = snap_reg[7:0];
            end
            ADDR_EVT: begin
                rd_byte[EVT_CMP_BIT] = transfer_complete_flag_reg;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    always_comb begin
        pready_next = setup;
        pslverr_next = setup & ~hit;
        prdata_next = prdata_reg;
        if (setup && !pwrite) begin
            prdata_next = {24'h00_0000, rd_byte};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            prdata_reg <= prdata_next;
        end
    end

    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign prdata = prdata_reg;

    // Snapshot: the lower bytes are caught in the same cycle as the top
    // byte goes to prdata, so the four bytes belong to one count value
    always_comb begin
        cap_next = cap_reg;
        snap_next = snap_reg;
        if (setup && !pwrite && paddr == ADDR_CNT_HH) begin
            cap_next = transfer_byte_count[23:0];
        end
        if (rd_top) begin
            snap_next = cap_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_reg <= SNAP_RST;
            snap_reg <= SNAP_RST;
        end else begin
            cap_reg <= cap_next;
            snap_reg <= snap_next;
        end
    end

    // Byte-wise writes into the counter, MSB at the lowest index
    always_comb begin
        cnt_wr = 4'h0;
        if (wr_ok) begin
            cnt_wr[3] = (paddr == ADDR_CNT_HH);
            cnt_wr[2] = (paddr == ADDR_CNT_HL);
            cnt_wr[1] = (paddr == ADDR_CNT_LH);
            cnt_wr[0] = (paddr == ADDR_CNT_LL);
        end
    end

    // In unlimited mode the count is frozen and never ends the transfer
    assign cnt_dec = pkt_report.done & (state_reg == HCSC_RUN)
                     & ~unlimited_size_flag_reg;

    // A zero count on IN ends at once; on OUT it ends after the
    // zero-length packet has been reported
    always_comb begin
        complete = 1'b0;
        if (state_reg == HCSC_RUN && !unlimited_size_flag_reg) begin
            if (pkt_report.done && transfer_byte_count <= {21'h0, pkt_report.bytes}) begin
                complete = 1'b1;
            end else if (tid_reg != TID_OUT && transfer_byte_count == CNT_RST) begin
                complete = 1'b1;
            end
        end
    end

    hcsc_byte_counter u_counter (
        .pclk(pclk),
        .presetn(presetn),
        .byte_wr(cnt_wr),
        .wdata(wbyte),
        .dec_en(cnt_dec),
        .dec_amt(pkt_report.bytes),
        .count(transfer_byte_count)
    );

    // Configuration registers
    always_comb begin
        max_packet_bytes_next = max_packet_bytes_reg;
        tid_next = tid_reg;
        unlimited_size_flag_next = unlimited_size_flag_reg;
        if (wr_ok && paddr == ADDR_MPS_H) begin
            // Bits 7-2 are not stored, so a stray one cannot corrupt the size
            max_packet_bytes_next[9:8] = wbyte[1:0];
        end
        if (wr_ok && paddr == ADDR_MPS_L) begin
            max_packet_bytes_next[7:0] = wbyte;
        end
        if (wr_ok && paddr == ADDR_CFG1) begin
            tid_next = wbyte[CFG1_TID_LSB +: 2];
            unlimited_size_flag_next = wbyte[CFG1_FREE_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            max_packet_bytes_reg <= MPS_RST;
            tid_reg <= TID_RST;
            unlimited_size_flag_reg <= 1'b0;
        end else begin
            max_packet_bytes_reg <= max_packet_bytes_next;
            tid_reg <= tid_next;
            unlimited_size_flag_reg <= unlimited_size_flag_next;
        end
    end

    // Transaction control
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            HCSC_IDLE: begin
                if (wr_ok && paddr == ADDR_CFG0 && wbyte[CFG0_GO_BIT]) begin
                    state_next = HCSC_RUN;
                end
            end
            HCSC_RUN: begin
                if (complete) begin
                    state_next = HCSC_IDLE;
                end else if (wr_ok && paddr == ADDR_CFG0 && !wbyte[CFG0_GO_BIT]) begin
                    // Stopping keeps the remaining count so the transfer can resume
                    state_next = HCSC_IDLE;
                end
            end
        endcase
    end

    // Set beats a write-one clear landing in the same cycle
    always_comb begin
        transfer_complete_flag_next = transfer_complete_flag_reg;
        if (wr_ok && paddr == ADDR_EVT && wbyte[EVT_CMP_BIT]) begin
            transfer_complete_flag_next = 1'b0;
        end
        if (complete) begin
            transfer_complete_flag_next = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= HCSC_IDLE;
            transfer_complete_flag_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            transfer_complete_flag_reg <= transfer_complete_flag_next;
        end
    end

    // Request to the token engine; length lags the count by one cycle
    always_comb begin
        req_next.active = (state_next == HCSC_RUN);
        req_next.dir_out = (tid_reg == TID_OUT);
        len_wide = transfer_byte_count;
        if (unlimited_size_flag_reg ||
            transfer_byte_count > {22'h0, max_packet_bytes_reg}) begin
            len_wide = {22'h0, max_packet_bytes_reg};
        end
        req_next.len = len_wide[MPS_W-1:0];
        req_next.zero_len = req_next.active & req_next.dir_out
                            & (len_wide == CNT_RST);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_reg <= '0;
        end else begin
            req_reg <= req_next;
        end
    end

    assign pkt_request = req_reg;

endmodule

//--- testbench/hcsc_engine_model.sv
`timescale 1ns/100ps
module hcsc_engine_model
    import hcsc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire hcsc_req_s req,
    output hcsc_pkt_s rpt
);
    logic [3:0] wait_reg;
    // A long gap keeps done pulses apart so len is current when sampled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_reg <= 4'h0;
            rpt <= '0;
        end else if (req.active && wait_reg == 4'hC) begin
            wait_reg <= 4'h0;
            rpt.done <= 1'b1;
            rpt.bytes <= req.zero_len ? 11'h000 : {1'b0, req.len};
        end else begin
            // Byte count is only valid with done; toggle it otherwise
            rpt.done <= 1'b0;
            rpt.bytes <= ~rpt.bytes;
            wait_reg <= req.active ? wait_reg + 4'h1 : 4'h0;
        end
    end
endmodule

//--- testbench/hcsc_host_channel_size_counter_chk.sv
`timescale 1ns/100ps
module hcsc_host_channel_size_counter_chk
    import hcsc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire hcsc_pkt_s pkt_report,
    input wire hcsc_req_s pkt_request
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic mapped;
    assign mapped = (paddr[11:5] == 7'h28 && paddr[1:0] == 2'b00) || paddr == ADDR_EVT;
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_done;
        psel && penable && pready;
    endsequence
    a_ready_after_setup: assert property (s_setup |=> pready)
        else $error("pready missing after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready held two cycles");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("pready outside access");
    a_read_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("prdata upper bits set");
    a_err_unmapped: assert property (s_setup |=> pslverr == !mapped)
        else $error("pslverr wrong for address");
    a_size_high_zero: assert property (
        s_setup ##0 (!pwrite && paddr == ADDR_MPS_H) |=> prdata[7:2] == 6'h0)
        else $error("size high unused bits set");
    a_zlp_shape: assert property (
        pkt_request.zero_len |-> pkt_request.active && pkt_request.dir_out
        && pkt_request.len == '0)
        else $error("zero length request malformed");
    a_go_clear_stops: assert property (
        s_done ##0 (pwrite && paddr == ADDR_CFG0 && !pwdata[CFG0_GO_BIT])
        |=> !pkt_request.active)
        else $error("channel still active after stop");
endmodule
bind hcsc_host_channel_size_counter hcsc_host_channel_size_counter_chk u_chk (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pkt_report(pkt_report), .pkt_request(pkt_request));

//--- testbench/hcsc_host_channel_size_counter_tb.sv
`timescale 1ns/100ps
module hcsc_host_channel_size_counter_tb
    import hcsc_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, saw_zlp;
    logic [APB_AW-1:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0] rd;
    hcsc_pkt_s pkt_report;
    hcsc_req_s pkt_request;
    int miscompares, n_checks, dones, d0;
    logic [11:0] r_addr [8] = '{ADDR_MPS_H, ADDR_MPS_L, ADDR_CNT_HH, ADDR_CNT_HL,
        ADDR_CNT_LH, ADDR_CNT_LL, 12'h520, 12'h53C};
    logic [7:0] r_wd [8] = '{8'h03, 8'hA5, 8'h12, 8'h34, 8'h56, 8'h78, 8'h5A, 8'h5A};
    logic [7:0] r_exp [8] = '{8'h03, 8'hA5, 8'h12, 8'h34, 8'h56, 8'h78, 8'h00, 8'h00};
    logic r_err [8] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    hcsc_host_channel_size_counter dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pkt_report(pkt_report), .pkt_request(pkt_request));
    hcsc_engine_model engine (.pclk(pclk), .presetn(presetn), .req(pkt_request), .rpt(pkt_report));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (pkt_report.done === 1'b1) dones <= dones + 1;
        if (pkt_request.zero_len === 1'b1) saw_zlp <= 1'b1;
    end
    task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic rchk(input logic [11:0] a, input logic [7:0] exp, input string nm);
        apb(a, 1'b0, 8'h00);
        chk(nm, {24'h0, exp}, {24'h0, rd});
    endtask
    task automatic cnt_set(input logic [31:0] c);
        for (int k = 0; k < 4; k++) apb(ADDR_CNT_HH + 12'(4 * k), 1'b1, c[31 - 8 * k -: 8]);
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #50000;
        miscompares++;
        report_and_stop();
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata, presetn, saw_zlp} = '0;
        {miscompares, n_checks, dones} = '0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("request", 32'h0, {19'h0, pkt_request});
        foreach (r_addr[i]) rchk(r_addr[i], 8'h00, "reset value");
        foreach (r_addr[i]) apb(r_addr[i], 1'b1, r_wd[i]);
        foreach (r_addr[i]) begin
            rchk(r_addr[i], r_exp[i], "readback");
            chk("slverr", {31'h0, r_err[i]}, {31'h0, err});
        end
        // Count writes go live at once, so the frozen copy must differ
        apb(ADDR_CNT_LL, 1'b1, 8'h9C);
        rchk(ADDR_CNT_LL, 8'h78, "frozen low");
        rchk(ADDR_CNT_HH, 8'h12, "top byte");
        rchk(ADDR_CNT_LL, 8'h9C, "fresh low");
        apb(ADDR_MPS_H, 1'b1, 8'h00);
        apb(ADDR_MPS_L, 1'b1, 8'h40);
        // Not a multiple of the size, so the last packet is a short one
        cnt_set(32'h0000_00F0);
        apb(ADDR_CFG1, 1'b1, {TID_OUT, 6'h00});
        d0 = dones;
        apb(ADDR_CFG0, 1'b1, 8'h01);
        while (dones < d0 + 1) @(posedge pclk);
        repeat (2) @(posedge pclk);
        chk("request length", 32'h40, {22'h0, pkt_request.len});
        chk("request out", 32'h1, {31'h0, pkt_request.dir_out});
        rchk(ADDR_CNT_HH, 8'h00, "running top");
        rchk(ADDR_CNT_HL, 8'h00, "running high");
        rchk(ADDR_CNT_LH, 8'h00, "running mid");
        rchk(ADDR_CNT_LL, 8'hB0, "running low");
        while (dones < d0 + 3) @(posedge pclk);
        repeat (2) @(posedge pclk);
        chk("last length", 32'h30, {22'h0, pkt_request.len});
        while (pkt_request.active !== 1'b0) @(posedge pclk);
        chk("packets", 32'd4, 32'(dones - d0));
        rchk(ADDR_CFG0, 8'h00, "go cleared");
        rchk(ADDR_EVT, 8'h01, "complete flag");
        apb(ADDR_EVT, 1'b1, 8'h01);
        cnt_set(32'h0);
        d0 = dones;
        apb(ADDR_CFG0, 1'b1, 8'h01);
        while (pkt_request.active !== 1'b0) @(posedge pclk);
        chk("zero length seen", 32'h1, {31'h0, saw_zlp});
        chk("zero length packets", 32'd1, 32'(dones - d0));
        rchk(ADDR_EVT, 8'h01, "zero length complete");
        apb(ADDR_EVT, 1'b1, 8'h01);
        // An IN run with nothing to move ends without any packet
        apb(ADDR_CFG1, 1'b1, {TID_IN, 6'h00});
        d0 = dones;
        apb(ADDR_CFG0, 1'b1, 8'h01);
        rchk(ADDR_CFG0, 8'h00, "zero count in");
        chk("zero count in packets", 32'd0, 32'(dones - d0));
        rchk(ADDR_EVT, 8'h01, "zero count in flag");
        apb(ADDR_EVT, 1'b1, 8'h01);
        cnt_set(32'h0000_0040);
        apb(ADDR_CFG1, 1'b1, {TID_IN, 5'h00, 1'b1});
        d0 = dones;
        apb(ADDR_CFG0, 1'b1, 8'h01);
        while (dones < d0 + 3) @(posedge pclk);
        chk("unlimited active", 32'h1, {31'h0, pkt_request.active});
        rchk(ADDR_CNT_HH, 8'h00, "unlimited top");
        rchk(ADDR_CNT_LL, 8'h40, "unlimited low");
        apb(ADDR_CFG0, 1'b1, 8'h00);
        rchk(ADDR_CFG0, 8'h00, "stopped");
        rchk(ADDR_EVT, 8'h00, "no completion");
        apb(ADDR_CFG0, 1'b1, 8'h01);
        rchk(ADDR_CFG0, 8'h01, "resumed");
        // Reset in mid-run must drop the request and clear the config, size and count registers
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("request after reset", 32'h0, {19'h0, pkt_request});
        foreach (r_addr[i]) rchk(r_addr[i], 8'h00, "mid-run reset");
        rchk(ADDR_CFG0, 8'h00, "go after reset");
        rchk(ADDR_CFG1, 8'h00, "config after reset");
        report_and_stop();
    end
endmodule
